// ===== src/psb_defines.svh
`ifndef PSB_DEFINES_SVH
`define PSB_DEFINES_SVH

// System clock period
`define PSB_CLK_PERIOD_PS 25000
`define PSB_TIMER_W 12

// Refresh interval (longest, rounds down) and refresh busy time (least, rounds up)
`define PSB_REFRESH_INTERVAL_NS 4000
`define PSB_REFRESH_INTERVAL_CYC ((`PSB_REFRESH_INTERVAL_NS * 1000) / `PSB_CLK_PERIOD_PS)
`define PSB_REFRESH_BUSY_NS 100
`define PSB_REFRESH_BUSY_CYC \
  ((`PSB_REFRESH_BUSY_NS * 1000 + `PSB_CLK_PERIOD_PS - 1) / `PSB_CLK_PERIOD_PS)

// Deep power-down entry time (longest, rounds down)
`define PSB_PD_ENTRY_NS 10000
`define PSB_PD_ENTRY_CYC ((`PSB_PD_ENTRY_NS * 1000) / `PSB_CLK_PERIOD_PS)

// Configuration register zero: reset value, field positions, register-space address
`define PSB_CFG_RESET 16'h8f2f
`define PSB_CFG_PD_BIT 15
`define PSB_CFG_DS_MSB 14
`define PSB_CFG_DS_LSB 12
`define PSB_CFG_LAT_MSB 7
`define PSB_CFG_LAT_LSB 4
`define PSB_CFG_FIXED_BIT 3
`define PSB_CFG_HYBRID_BIT 2
`define PSB_CFG_BL_MSB 1
`define PSB_CFG_BL_LSB 0
`define PSB_CFG0_ADDR 32'h0000_0000

`endif

// ===== src/psb_pkg.sv
package psb_pkg;

  typedef enum logic [3:0] {
    LINK_IDLE    = 4'h1,
    LINK_CMDADDR = 4'h2,
    LINK_LATENCY = 4'h4,
    LINK_DATA    = 4'h8
  } psb_link_state_t;

  typedef enum logic [3:0] {
    PWR_RUN   = 4'h1,
    PWR_ENTER = 4'h2,
    PWR_DEEP  = 4'h4,
    PWR_WAKE  = 4'h8
  } psb_pwr_state_t;

  typedef enum logic [2:0] {
    BURST_LINEAR = 3'h1,
    BURST_LEGACY = 3'h2,
    BURST_HYBRID = 3'h4
  } psb_burst_t;

  // Reserved codes fall back to the slowest setting
  function automatic logic [3:0] latency_clocks(input logic [3:0] code);
    case (code)
      4'h0:    latency_clocks = 4'h5;
      4'h1:    latency_clocks = 4'h6;
      4'h2:    latency_clocks = 4'h7;
      4'he:    latency_clocks = 4'h3;
      4'hf:    latency_clocks = 4'h4;
      default: latency_clocks = 4'h7;
    endcase
  endfunction

  // Low address bits that wrap inside one group
  function automatic logic [5:0] group_mask(input logic [1:0] code);
    case (code)
      2'h0:    group_mask = 6'h3f;
      2'h1:    group_mask = 6'h1f;
      2'h2:    group_mask = 6'h07;
      default: group_mask = 6'h0f;
    endcase
  endfunction

endpackage

// ===== src/psb_sync2.sv
`timescale 1ns/1ps
`default_nettype none

module psb_sync2 (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic d,
  output logic      q
);

  logic stage1;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      stage1 <= 1'b0;
      q      <= 1'b0;
    end else begin
      stage1 <= d;
      q      <= stage1;
    end
  end

endmodule

`default_nettype wire

// ===== src/psb_burst_addr.sv
`timescale 1ns/1ps
`default_nettype none

module psb_burst_addr (
  input  wire logic                clk,
  input  wire logic                rst_n,
  input  wire logic                load,
  input  wire logic                step,
  input  wire logic [31:0]         startAddr,
  input  wire psb_pkg::psb_burst_t mode,
  input  wire logic [5:0]          mask,
  output logic      [31:0]         addr
);

  logic       wrapping;
  logic [5:0] startLow;
  logic [5:0] nextLow;

  assign nextLow = (addr[5:0] + 6'h01) & mask;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      addr     <= 32'h0000_0000;
      wrapping <= 1'b0;
      startLow <= 6'h00;
    end else if (load) begin
      addr     <= startAddr;
      startLow <= startAddr[5:0] & mask;
      wrapping <= (mode != psb_pkg::BURST_LINEAR);
    end else if (step) begin
      if (!wrapping) begin
        addr <= addr + 32'h1;
      end else if (mode == psb_pkg::BURST_HYBRID && nextLow == startLow) begin
        addr     <= (addr | {26'h0, mask}) + 32'h1;
        wrapping <= 1'b0;
      end else begin
        addr <= {addr[31:6], (addr[5:0] & ~mask) | nextLow};
      end
    end
  end

endmodule

`default_nettype wire

// ===== src/psb_burst_latency_config.sv
// What this block does
// - Hybrid: wrap group once, then linear onward
// - Legacy wrap: stay inside aligned group
// - Group sizes 64, 32, 16, 8 words
// - Linear: increment address every word
// - Reads and memory writes wait initial latency
// - Latency defaults to seven clocks
// - Pending refresh: strobe high, extra latency
// - Register writes take data without latency
// - Refresh may overlap register write capture
// - Fixed latency: strobe high, double latency
// - Fixed latency set after reset
// - Variable latency doubles only for refresh
// - Drive strength field, reset zero
// - Writing zero enters power-down, refresh stops
// - Array contents invalid after power-down
// - Select pulse or reset wakes device
// - Power-down ignores all but select, reset
// - Wake restores power-down enable to one
// - Hybrid bit chooses hybrid or legacy
// - Burst length codes 64, 32, 8, 16
// - Latency code decode, others reserved
`timescale 1ns/1ps
`default_nettype none
`include "psb_defines.svh"

module psb_burst_latency_config (
  input  wire logic        clock,
  input  wire logic        arst_n,
  input  wire logic        linkClk,
  input  wire logic        csN,
  input  wire logic        cmdAddrValid,
  input  wire logic        cmdAddrRead,
  input  wire logic        cmdAddrRegSpace,
  input  wire logic        cmdAddrLinear,
  input  wire logic [31:0] cmdAddr,
  input  wire logic        wordStep,
  input  wire logic [15:0] wrData,
  output logic             strobeOut,
  output logic             strobeOeN,
  output logic             dataPhase,
  output logic [31:0]      wordAddr,
  output logic [15:0]      regRdData,
  output logic             regWriteDone,
  output logic [2:0]       driveStrength,
  output logic             fixedLatency,
  output logic [3:0]       latencyClocks,
  output logic             deepPowerDownState,
  output logic             arrayDataLost,
  output logic             refreshBusy
);

  localparam logic [`PSB_TIMER_W-1:0] REFRESH_INTERVAL = `PSB_TIMER_W'(`PSB_REFRESH_INTERVAL_CYC);
  localparam logic [`PSB_TIMER_W-1:0] REFRESH_BUSY     = `PSB_TIMER_W'(`PSB_REFRESH_BUSY_CYC);
  localparam logic [`PSB_TIMER_W-1:0] PD_ENTRY         = `PSB_TIMER_W'(`PSB_PD_ENTRY_CYC);

  // ---------------- Link clock domain ----------------
  logic                     linkRst_n;
  psb_pkg::psb_link_state_t linkState;
  logic [15:0]              configRegZero;
  logic                     doubleLat;
  logic                     isRegWrite;
  logic [3:0]               latCount;
  logic                     refreshLink;
  logic                     powerDownLink;
  logic                     wakeTogLink;
  logic                     wakeTogSeen;
  logic                     addrLoad;
  logic                     addrStep;
  logic                     cfgHit;
  psb_pkg::psb_burst_t      burstMode;
  logic [5:0]               groupMask;
  logic [3:0]               baseLat;

  // ---------------- System clock domain ----------------
  psb_pkg::psb_pwr_state_t  pwrState;
  logic                     csActiveSys;
  logic                     pdRequestSys;
  logic                     wakeTog;
  logic                     armed;
  logic [`PSB_TIMER_W-1:0]  pwrTimer;
  logic [`PSB_TIMER_W-1:0]  refreshTimer;
  logic [`PSB_TIMER_W-1:0]  refreshRun;

  psb_sync2 u_link_rst (
    .clk   (linkClk),
    .rst_n (arst_n),
    .d     (1'b1),
    .q     (linkRst_n)
  );

  psb_sync2 u_refresh_to_link (
    .clk   (linkClk),
    .rst_n (linkRst_n),
    .d     (refreshBusy),
    .q     (refreshLink)
  );

  psb_sync2 u_pd_to_link (
    .clk   (linkClk),
    .rst_n (linkRst_n),
    .d     (deepPowerDownState),
    .q     (powerDownLink)
  );

  psb_sync2 u_wake_to_link (
    .clk   (linkClk),
    .rst_n (linkRst_n),
    .d     (wakeTog),
    .q     (wakeTogLink)
  );

  psb_sync2 u_cs_to_sys (
    .clk   (clock),
    .rst_n (arst_n),
    .d     (~csN),
    .q     (csActiveSys)
  );

  psb_sync2 u_pd_to_sys (
    .clk   (clock),
    .rst_n (arst_n),
    .d     (~configRegZero[`PSB_CFG_PD_BIT]),
    .q     (pdRequestSys)
  );

  // hybrid bit only for wrapped bursts
  assign burstMode = cmdAddrLinear ? psb_pkg::BURST_LINEAR :
                     (configRegZero[`PSB_CFG_HYBRID_BIT] ? psb_pkg::BURST_LEGACY
                                                         : psb_pkg::BURST_HYBRID);
  assign groupMask = psb_pkg::group_mask(configRegZero[`PSB_CFG_BL_MSB:`PSB_CFG_BL_LSB]);
  assign baseLat   = psb_pkg::latency_clocks(configRegZero[`PSB_CFG_LAT_MSB:`PSB_CFG_LAT_LSB]);
  assign addrLoad  = (linkState == psb_pkg::LINK_CMDADDR) && cmdAddrValid && !csN;
  assign addrStep  = (linkState == psb_pkg::LINK_DATA) && wordStep && !csN && !isRegWrite;

  psb_burst_addr u_addr (
    .clk       (linkClk),
    .rst_n     (linkRst_n),
    .load      (addrLoad),
    .step      (addrStep),
    .startAddr (cmdAddr),
    .mode      (burstMode),
    .mask      (groupMask),
    .addr      (wordAddr)
  );

  always_ff @(posedge linkClk or negedge linkRst_n) begin
    if (!linkRst_n) begin
      linkState  <= psb_pkg::LINK_IDLE;
      doubleLat  <= 1'b0;
      isRegWrite <= 1'b0;
      cfgHit     <= 1'b0;
      latCount   <= 4'h0;
      strobeOut  <= 1'b0;
      strobeOeN  <= 1'b1;
      dataPhase  <= 1'b0;
    end else begin
      unique case (linkState)
        psb_pkg::LINK_IDLE: begin
          if (!csN && !powerDownLink) begin
            doubleLat <= configRegZero[`PSB_CFG_FIXED_BIT] | refreshLink;
            strobeOut <= configRegZero[`PSB_CFG_FIXED_BIT] | refreshLink;
            strobeOeN <= 1'b0;
            linkState <= psb_pkg::LINK_CMDADDR;
          end
        end
        psb_pkg::LINK_CMDADDR: begin
          if (csN) begin
            strobeOut <= 1'b0;
            strobeOeN <= 1'b1;
            linkState <= psb_pkg::LINK_IDLE;
          end else if (cmdAddrValid) begin
            strobeOut <= 1'b0;
            strobeOeN <= 1'b1;
            // Address is only valid with the command pulse
            cfgHit    <= (cmdAddr == `PSB_CFG0_ADDR);
            if (!cmdAddrRead && cmdAddrRegSpace) begin
              isRegWrite <= 1'b1;
              dataPhase  <= 1'b1;
              linkState  <= psb_pkg::LINK_DATA;
            end else begin
              isRegWrite <= 1'b0;
              latCount   <= doubleLat ? 4'(baseLat << 1) : baseLat;
              linkState  <= psb_pkg::LINK_LATENCY;
            end
          end
        end
        psb_pkg::LINK_LATENCY: begin
          if (csN) begin
            linkState <= psb_pkg::LINK_IDLE;
          end else if (latCount <= 4'h1) begin
            dataPhase <= 1'b1;
            linkState <= psb_pkg::LINK_DATA;
          end else begin
            latCount <= latCount - 4'h1;
          end
        end
        psb_pkg::LINK_DATA: begin
          if (csN) begin
            dataPhase  <= 1'b0;
            isRegWrite <= 1'b0;
            linkState  <= psb_pkg::LINK_IDLE;
          end
        end
        default: begin
          strobeOut <= 1'b0;
          strobeOeN <= 1'b1;
          dataPhase <= 1'b0;
          linkState <= psb_pkg::LINK_IDLE;
        end
      endcase
    end
  end

  // Configuration register; a wake event beats a write landing in the same cycle, for the power-down bit only
  always_ff @(posedge linkClk or negedge linkRst_n) begin
    if (!linkRst_n) begin
      configRegZero <= `PSB_CFG_RESET;
      regWriteDone  <= 1'b0;
      wakeTogSeen   <= 1'b0;
    end else begin
      regWriteDone <= 1'b0;
      wakeTogSeen  <= wakeTogLink;
      if (linkState == psb_pkg::LINK_DATA && isRegWrite && wordStep && !csN
          && !regWriteDone && cfgHit) begin
        configRegZero <= wrData;
        regWriteDone  <= 1'b1;
      end
      if (wakeTogLink != wakeTogSeen) begin
        configRegZero[`PSB_CFG_PD_BIT] <= 1'b1;
      end
    end
  end

  // regWriteDone blocks only the word after a register write; later words of the select write again
  always_ff @(posedge linkClk or negedge linkRst_n) begin
    if (!linkRst_n) begin
      regRdData     <= `PSB_CFG_RESET;
      driveStrength <= 3'h0;
      fixedLatency  <= 1'b1;
      latencyClocks <= 4'h7;
    end else begin
      regRdData     <= configRegZero;
      driveStrength <= configRegZero[`PSB_CFG_DS_MSB:`PSB_CFG_DS_LSB];
      fixedLatency  <= configRegZero[`PSB_CFG_FIXED_BIT];
      latencyClocks <= baseLat;
    end
  end

  // Power state; exit needs select seen low then high
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      pwrState           <= psb_pkg::PWR_RUN;
      pwrTimer           <= '0;
      armed              <= 1'b1;
      wakeTog            <= 1'b0;
      deepPowerDownState <= 1'b0;
    end else begin
      unique case (pwrState)
        psb_pkg::PWR_RUN: begin
          // The stale request is still seen until the link restores the bit
          if (!pdRequestSys) begin
            armed <= 1'b1;
          end
          if (pdRequestSys && armed) begin
            pwrTimer <= PD_ENTRY;
            pwrState <= psb_pkg::PWR_ENTER;
          end
        end
        psb_pkg::PWR_ENTER: begin
          if (pwrTimer <= `PSB_TIMER_W'(1)) begin
            deepPowerDownState <= 1'b1;
            pwrState           <= psb_pkg::PWR_DEEP;
          end else begin
            pwrTimer <= pwrTimer - `PSB_TIMER_W'(1);
          end
        end
        psb_pkg::PWR_DEEP: begin
          if (csActiveSys) begin
            pwrState <= psb_pkg::PWR_WAKE;
          end
        end
        psb_pkg::PWR_WAKE: begin
          if (!csActiveSys) begin
            deepPowerDownState <= 1'b0;
            wakeTog            <= ~wakeTog;
            armed              <= 1'b0;
            pwrState           <= psb_pkg::PWR_RUN;
          end
        end
        default: begin
          deepPowerDownState <= 1'b0;
          pwrState           <= psb_pkg::PWR_RUN;
        end
      endcase
    end
  end

  // Data loss is sticky until reset; a reset also loses refresh
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      arrayDataLost <= 1'b0;
    end else if (pwrState == psb_pkg::PWR_ENTER) begin
      arrayDataLost <= 1'b1;
    end
  end

  // Self refresh starts only between selects, so a select that starts meanwhile pays latency
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      refreshTimer <= REFRESH_INTERVAL;
      refreshRun   <= '0;
      refreshBusy  <= 1'b0;
    end else if (pwrState != psb_pkg::PWR_RUN) begin
      refreshTimer <= REFRESH_INTERVAL;
      refreshRun   <= '0;
      refreshBusy  <= 1'b0;
    end else begin
      if (refreshBusy && refreshRun == '0 && !csActiveSys) begin
        refreshRun <= REFRESH_BUSY;
      end else if (refreshRun == `PSB_TIMER_W'(1)) begin
        refreshRun  <= '0;
        refreshBusy <= 1'b0;
      end else if (refreshRun != '0) begin
        refreshRun <= refreshRun - `PSB_TIMER_W'(1);
      end
      // A new request beats the end of the last refresh
      if (refreshTimer <= `PSB_TIMER_W'(1)) begin
        refreshTimer <= REFRESH_INTERVAL;
        refreshBusy  <= 1'b1;
      end else begin
        refreshTimer <= refreshTimer - `PSB_TIMER_W'(1);
      end
    end
  end

endmodule

`default_nettype wire

// ===== verification/psb_burst_latency_config_sva.sv
`timescale 1ns/1ps
`default_nettype none
module psb_burst_latency_config_sva (
  input wire logic        clock,
  input wire logic        arst_n,
  input wire logic        linkClk,
  input wire logic        csN,
  input wire logic        cmdAddrValid,
  input wire logic        cmdAddrRead,
  input wire logic        cmdAddrRegSpace,
  input wire logic        cmdAddrLinear,
  input wire logic        wordStep,
  input wire logic        strobeOut,
  input wire logic        strobeOeN,
  input wire logic        dataPhase,
  input wire logic [31:0] wordAddr,
  input wire logic [15:0] regRdData,
  input wire logic [2:0]  driveStrength,
  input wire logic        fixedLatency,
  input wire logic [3:0]  latencyClocks,
  input wire logic        deepPowerDownState,
  input wire logic        arrayDataLost,
  input wire logic        refreshBusy
);
  localparam int PdMax = 404;
  logic        take;
  logic        memLin;
  logic        memWrap;
  logic [4:0]  cnt;
  logic [4:0]  expLat;
  logic [31:0] grpMask;
  // Strobe driven low-enable marks an open command phase
  assign take = cmdAddrValid && !csN && !strobeOeN;
  assign grpMask = regRdData[1] ? (regRdData[0] ? 32'h0f : 32'h07)
                                : (regRdData[0] ? 32'h1f : 32'h3f);
  always_ff @(posedge linkClk or negedge arst_n) begin
    if (!arst_n) begin
      cnt <= 5'h0;
      expLat <= 5'h0;
      memLin <= 1'b0;
      memWrap <= 1'b0;
    end else if (take) begin
      cnt <= 5'h0;
      expLat <= (cmdAddrRegSpace && !cmdAddrRead) ? 5'h0
              : ({1'b0, latencyClocks} << strobeOut);
      memLin <= !cmdAddrRegSpace && cmdAddrLinear;
      memWrap <= !cmdAddrRegSpace && !cmdAddrLinear;
    end else if (cnt != 5'h1f) begin
      cnt <= cnt + 5'h1;
    end
  end
  strobe_fixed_a: assert property (@(posedge linkClk) disable iff (!arst_n)
    !strobeOeN && fixedLatency |-> strobeOut) else $error("strobe low under fixed latency");
  strobe_release_a: assert property (@(posedge linkClk) disable iff (!arst_n)
    dataPhase |-> strobeOeN) else $error("strobe driven in data phase");
  regwr_nolat_a: assert property (@(posedge linkClk) disable iff (!arst_n)
    take && cmdAddrRegSpace && !cmdAddrRead |-> ##1 dataPhase) else $error("reg write delayed");
  latency_count_a: assert property (@(posedge linkClk) disable iff (!arst_n)
    $rose(dataPhase) |-> cnt == expLat) else $error("initial latency count wrong");
  linear_step_a: assert property (@(posedge linkClk) disable iff (!arst_n)
    dataPhase && wordStep && memLin |=> wordAddr == $past(wordAddr) + 32'h1)
    else $error("linear step wrong");
  legacy_wrap_a: assert property (@(posedge linkClk) disable iff (!arst_n)
    dataPhase && wordStep && memWrap && regRdData[2] |=>
    (wordAddr & ~grpMask) == ($past(wordAddr) & ~grpMask) &&
    (wordAddr & grpMask) == (($past(wordAddr) + 32'h1) & grpMask)) else $error("wrap step wrong");
  pd_entry_a: assert property (@(posedge clock) disable iff (!arst_n)
    $rose(arrayDataLost) |-> ##[1:PdMax] deepPowerDownState) else $error("power-down late");
  pd_norefresh_a: assert property (@(posedge clock) disable iff (!arst_n)
    deepPowerDownState |-> !refreshBusy) else $error("refresh in power-down");
  pd_lost_a: assert property (@(posedge clock) disable iff (!arst_n)
    $rose(deepPowerDownState) |-> arrayDataLost) else $error("array not marked lost");
  pd_ignore_a: assert property (@(posedge linkClk) disable iff (!arst_n)
    deepPowerDownState |-> strobeOeN && !dataPhase) else $error("link active in power-down");
  reset_defaults_a: assert property (@(posedge clock) disable iff (!arst_n)
    $rose(arst_n) |-> fixedLatency && latencyClocks == 4'h7 && driveStrength == 3'h0 &&
    regRdData[1:0] == 2'b11) else $error("reset defaults wrong");
  cover property (@(posedge linkClk) take && cmdAddrRegSpace && !cmdAddrRead);
  cover property (@(posedge linkClk) dataPhase && wordStep && memWrap && !regRdData[2]);
  cover property (@(posedge clock) $rose(deepPowerDownState));
endmodule
`default_nettype wire

// ===== verification/psb_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module psb_host_model (
  output logic             linkClk,
  output logic             csN,
  output logic             cmdAddrValid,
  output logic             cmdAddrRead,
  output logic             cmdAddrRegSpace,
  output logic             cmdAddrLinear,
  output logic [31:0]      cmdAddr,
  output logic             wordStep,
  output logic [15:0]      wrData,
  input  wire logic        strobeOut,
  input  wire logic        strobeOeN,
  input  wire logic        dataPhase,
  input  wire logic [31:0] wordAddr
);
  logic ckRun;
  initial begin
    linkClk = 1'b0;
    ckRun = 1'b0;
    csN = 1'b1;
    {cmdAddrValid, cmdAddrRead, cmdAddrRegSpace, cmdAddrLinear, wordStep} = 5'h0;
    cmdAddr = 32'h0;
    wrData = 16'h0;
  end
  // Link clock stands still between frames
  always #32 linkClk = ckRun ? ~linkClk : 1'b0;
  task automatic idle(input int n);
    ckRun = 1'b1;
    repeat (n) @(posedge linkClk);
    #1 ckRun = 1'b0;
  endtask
  task automatic xfer(input logic rd, input logic rg, input logic lin, input logic [31:0] a,
                      input logic [15:0] d, input int n, output int lat, output logic stb,
                      output logic [31:0] fa, output logic [31:0] la);
    ckRun = 1'b1;
    @(posedge linkClk);
    #1 csN = 1'b0;
    repeat (2) @(posedge linkClk);
    #1 stb = strobeOut && !strobeOeN;
    cmdAddrValid = 1'b1;
    cmdAddrRead = rd;
    cmdAddrRegSpace = rg;
    cmdAddrLinear = lin;
    cmdAddr = a;
    @(posedge linkClk);
    #1 cmdAddrValid = 1'b0;
    cmdAddr = ~a;
    lat = 0;
    while (dataPhase !== 1'b1 && lat < 40) begin
      @(posedge linkClk);
      #1 lat++;
    end
    fa = wordAddr;
    wrData = d;
    wordStep = 1'b1;
    repeat (n) @(posedge linkClk);
    #1 wordStep = 1'b0;
    wrData = ~d;
    la = wordAddr;
    csN = 1'b1;
    repeat (2) @(posedge linkClk);
    #1 ckRun = 1'b0;
  endtask
  // Breaks protocol on purpose while the device sleeps
  task automatic noise(input int n);
    ckRun = 1'b1;
    repeat (3) @(posedge linkClk);
    #1 csN = 1'b0;
    cmdAddrValid = 1'b1;
    wordStep = 1'b1;
    repeat (n) @(posedge linkClk);
    #1 cmdAddrValid = 1'b0;
    wordStep = 1'b0;
    ckRun = 1'b0;
  endtask
  task automatic wake();
    #1 csN = 1'b0;
    #200 csN = 1'b1;
  endtask
endmodule
`default_nettype wire

// ===== verification/tb_psb_burst_latency_config.sv
`timescale 1ns/1ps
`default_nettype none
module tb_psb_burst_latency_config;
  typedef struct packed {
    logic [2:0]  cfgLow;
    logic        lin;
    logic [31:0] start;
    logic [7:0]  steps;
    logic [31:0] last;
  } psb_row_t;
  logic        clock, arst_n, linkClk, csN, cmdAddrValid, cmdAddrRead, cmdAddrRegSpace;
  logic        cmdAddrLinear, wordStep, strobeOut, strobeOeN, dataPhase, regWriteDone;
  logic        fixedLatency, deepPowerDownState, arrayDataLost, refreshBusy, stb;
  logic [31:0] cmdAddr, wordAddr, fa, la;
  logic [15:0] wrData, regRdData, cfgLast;
  logic [2:0]  driveStrength;
  logic [3:0]  latencyClocks;
  int          lat, numErrors, compares;
  logic [3:0]  codes[6] = '{4'h0, 4'h1, 4'h2, 4'he, 4'hf, 4'h5};
  logic [3:0]  lats[6] = '{4'h5, 4'h6, 4'h7, 4'h3, 4'h4, 4'h7};
  psb_row_t    rows[9] = '{
    '{3'b001, 1'b0, 32'h0000_102e, 8'h20, 32'h0000_1040},
    '{3'b000, 1'b0, 32'h0000_2003, 8'h40, 32'h0000_2040},
    '{3'b010, 1'b0, 32'h0000_0302, 8'h08, 32'h0000_0308},
    '{3'b011, 1'b0, 32'h0000_050a, 8'h10, 32'h0000_0510},
    '{3'b110, 1'b0, 32'h0000_070c, 8'h06, 32'h0000_070a},
    '{3'b111, 1'b0, 32'h0000_090a, 8'h10, 32'h0000_090a},
    '{3'b100, 1'b0, 32'h0000_0b03, 8'h3d, 32'h0000_0b00},
    '{3'b101, 1'b0, 32'h0000_0d2e, 8'h12, 32'h0000_0d20},
    '{3'b001, 1'b1, 32'h0000_0c3e, 8'h03, 32'h0000_0c41}};
  psb_burst_latency_config i_dut (.clock(clock), .arst_n(arst_n), .linkClk(linkClk), .csN(csN),
    .cmdAddrValid(cmdAddrValid), .cmdAddrRead(cmdAddrRead), .cmdAddrRegSpace(cmdAddrRegSpace),
    .cmdAddrLinear(cmdAddrLinear), .cmdAddr(cmdAddr), .wordStep(wordStep), .wrData(wrData),
    .strobeOut(strobeOut), .strobeOeN(strobeOeN), .dataPhase(dataPhase), .wordAddr(wordAddr),
    .regRdData(regRdData), .regWriteDone(regWriteDone), .driveStrength(driveStrength),
    .fixedLatency(fixedLatency), .latencyClocks(latencyClocks), .refreshBusy(refreshBusy),
    .deepPowerDownState(deepPowerDownState), .arrayDataLost(arrayDataLost));
  psb_host_model i_host (.linkClk(linkClk), .csN(csN), .cmdAddrValid(cmdAddrValid),
    .cmdAddrRead(cmdAddrRead), .cmdAddrRegSpace(cmdAddrRegSpace), .cmdAddr(cmdAddr),
    .cmdAddrLinear(cmdAddrLinear), .wordStep(wordStep), .wrData(wrData),
    .strobeOut(strobeOut), .strobeOeN(strobeOeN), .dataPhase(dataPhase), .wordAddr(wordAddr));
  always #12.5 clock = ~clock;
  function automatic logic [15:0] cfgw(input logic pd, input logic [2:0] ds, input logic [3:0] lc,
                                       input logic fx, input logic [2:0] low);
    return {pd, ds, 4'hf, lc, fx, low};
  endfunction
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      numErrors++;
      $display("mismatch %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic cfgWrite(input logic [15:0] v);
    i_host.xfer(1'b0, 1'b1, 1'b0, 32'h0, v, 1, lat, stb, fa, la);
    cfgLast = v;
    chk("write latency", 32'h0, lat);
    chk("config", {16'h0, v}, {16'h0, regRdData});
  endtask
  task automatic doReset();
    #1 arst_n = 1'b0;
    fork
      repeat (4) @(posedge clock);
      i_host.idle(3);
    join
    chk("reset config", cfgw(1'b1, 3'h0, 4'h2, 1'b1, 3'b111), regRdData);
    chk("reset latency", 32'h7, latencyClocks);
    chk("reset lost", 32'h0, arrayDataLost);
    @(posedge clock);
    #1 arst_n = 1'b1;
    i_host.idle(2);
  endtask
  task automatic completeRun();
    if (numErrors == 0 && compares > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  initial begin
    #1000000;
    numErrors++;
    completeRun();
  end
  initial begin
    clock = 1'b0;
    arst_n = 1'b0;
    numErrors = 0;
    compares = 0;
    doReset();
    i_host.xfer(1'b1, 1'b0, 1'b1, 32'h0, 16'h0, 1, lat, stb, fa, la);
    chk("default latency", 32'd14, lat);
    for (int i = 0; i < 6; i++) begin
      cfgWrite(cfgw(1'b1, i[2:0], codes[i], 1'b1, 3'b111));
      chk("latency code", {28'h0, lats[i]}, {28'h0, latencyClocks});
      chk("drive", i, driveStrength);
      i_host.xfer(1'b1, 1'b0, 1'b1, 32'h40, 16'h0, 1, lat, stb, fa, la);
      chk("fixed strobe", 32'h1, stb);
      chk("fixed latency", 2 * lats[i], lat);
    end
    foreach (rows[r]) begin
      cfgWrite(cfgw(1'b1, 3'h0, 4'he, 1'b0, rows[r].cfgLow));
      i_host.xfer(1'b1, 1'b0, rows[r].lin, rows[r].start, 16'h0, rows[r].steps, lat, stb, fa, la);
      chk("start", rows[r].start, fa);
      chk("end", rows[r].last, la);
      chk("var latency", stb ? 6 : 3, lat);
    end
    i_host.xfer(1'b0, 1'b1, 1'b0, 32'h1, 16'h0, 1, lat, stb, fa, la);
    chk("other reg", {16'h0, cfgLast}, {16'h0, regRdData});
    i_host.xfer(1'b1, 1'b1, 1'b0, 32'h0, 16'h0, 1, lat, stb, fa, la);
    chk("reg read latency", stb ? 6 : 3, lat);
    i_host.xfer(1'b0, 1'b1, 1'b0, 32'h0, cfgLast & 16'h7fff, 1, lat, stb, fa, la);
    for (int i = 0; i < 500 && deepPowerDownState !== 1'b1; i++) begin
      @(posedge clock);
    end
    chk("power-down", 32'h1, deepPowerDownState);
    chk("refresh", 32'h0, refreshBusy);
    chk("data lost", 32'h1, arrayDataLost);
    i_host.noise(6);
    chk("ignore", 32'h3, {dataPhase, strobeOeN, deepPowerDownState});
    @(posedge clock);
    i_host.wake();
    repeat (20) @(posedge clock);
    chk("wake", 32'h0, deepPowerDownState);
    i_host.idle(6);
    chk("enable bit", 32'h1, regRdData[15]);
    doReset();
    completeRun();
  end
endmodule
bind psb_burst_latency_config psb_burst_latency_config_sva i_sva (.clock(clock),
  .arst_n(arst_n), .linkClk(linkClk), .csN(csN), .cmdAddrValid(cmdAddrValid),
  .cmdAddrRead(cmdAddrRead), .cmdAddrRegSpace(cmdAddrRegSpace), .cmdAddrLinear(cmdAddrLinear),
  .wordStep(wordStep), .strobeOut(strobeOut), .strobeOeN(strobeOeN), .dataPhase(dataPhase),
  .wordAddr(wordAddr), .regRdData(regRdData), .driveStrength(driveStrength),
  .fixedLatency(fixedLatency), .latencyClocks(latencyClocks), .refreshBusy(refreshBusy),
  .deepPowerDownState(deepPowerDownState), .arrayDataLost(arrayDataLost));
`default_nettype wire
